/* File: src/poc_node_ctrl.sv */
// Purpose: protocol operation control and configuration registers of one cluster node
// Assumes: APB slave, zero wait states; cluster events are one-cycle pulses on ref_clk_in
// Notes: configuration is frozen while communication runs
// Functional notes
// - accept startup frames only when deviation lies within window of 0..1875 MT
// - halt on clock errors is allowed when the halt flag is set; default cleared
// - with halt flag cleared, clock errors leave the node normal-passive
// - promote passive to active after configured count (0..31) of valid cycle pairs
// - pair count zero means the node is never promoted from normal-passive to active
// - writing sleep flag true while asleep keeps node asleep at once
// - writing sleep flag false wakes the node locally at once
// - starting while asleep with sleep flag true holds ready until a wakeup pattern arrives
// - stop with sleep flag true puts node back to sleep
// - stop with sleep flag false keeps prior sleep or awake state
// - drift damping factor 0..20 MT applied in rate correction
// - coldstart indicator false when startup slot number is zero
// - nonzero startup slot: send startup frame there, coldstart true
// - channel encoding 1 A, 2 B, 3 both; default both
// - decoding correction 14..143 MT gives secondary to primary offset
// - clock sync compares primary point with expected sync frame arrival
`default_nettype none
`include "poc_params.svh"

module poc_node_ctrl
  import poc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // cluster events
  input wire logic integrated_in,
  input wire logic clock_error_in,
  input wire logic cycle_end_in,
  input wire logic cycle_odd_in,
  input wire logic corr_valid_in,
  input wire logic wakeup_a_in,
  input wire logic wakeup_b_in,
  input wire logic [10:0] slot_in,
  input wire logic slot_start_in,
  // clock sync measurements
  input wire mt_t start_dev_in,
  input wire logic sync_frame_in,
  input wire mt_t secondary_trp_in,
  input wire mt_t expected_in,
  input wire mt_t raw_rate_in,
  // node outputs
  output logic [5:0] poc_state_out,
  output logic asleep_out,
  output logic coldstart_out,
  output logic tx_startup_out,
  output logic [1:0] channels_out,
  output logic startup_accept_out,
  output logic [15:0] deviation_out,
  output logic [15:0] rate_corr_out
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [10:0] clamp11(input logic [31:0] v, input logic [10:0] lo,
                                          input logic [10:0] hi);
    if (v < {21'h000000, lo})
      clamp11 = lo;
    else if (v > {21'h000000, hi})
      clamp11 = hi;
    else
      clamp11 = v[10:0];
  endfunction

  function automatic logic [1:0] chan_fix(input logic [1:0] v);
    chan_fix = (v == 2'h0) ? `CHAN_AB : v;
  endfunction

  // ************************************************************
  // state and configuration
  // ************************************************************
  poc_state_t state_q;
  poc_state_t state_d;
  logic halt_en_q;
  logic sleep_en_q;
  logic asleep_q;
  logic [10:0] window_q;
  logic [4:0] pair_cfg_q;
  logic [4:0] damp_q;
  logic [1:0] chan_q;
  logic [7:0] dec_q;
  logic [10:0] slot_q;
  logic [4:0] pairs_q;
  logic even_ok_q;
  logic [31:0] prdata_q;
  logic tx_q;

  poc_sync_if sync ();

  // ************************************************************
  // apb decode
  // ************************************************************
  logic setup;
  logic wr;
  logic mapped;
  logic stopped;
  logic start_cmd;
  logic stop_cmd;
  logic wake_seen;

  assign setup = psel_in & ~penable_in;
  assign wr = psel_in & penable_in & pwrite_in;
  assign mapped = (paddr_in == `OFS_CTRL) || (paddr_in == `OFS_TIMING) ||
                  (paddr_in == `OFS_SYNC) || (paddr_in == `OFS_SLOT) ||
                  (paddr_in == `OFS_STATUS);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign stopped = (state_q == POC_CONFIG) || (state_q == POC_READY) || (state_q == POC_HALT);
  assign start_cmd = wr && (paddr_in == `OFS_CTRL) && pwdata_in[`CTRL_START_BIT];
  assign stop_cmd = wr && (paddr_in == `OFS_CTRL) && pwdata_in[`CTRL_STOP_BIT];
  // a wakeup only counts on a connected channel
  assign wake_seen = (wakeup_a_in & chan_q[0]) | (wakeup_b_in & chan_q[1]);

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      halt_en_q <= 1'b0;
      sleep_en_q <= 1'b0;
    end
    else if (wr && (paddr_in == `OFS_CTRL) && stopped)
    begin
      halt_en_q <= pwdata_in[`CTRL_HALT_EN_BIT];
      sleep_en_q <= pwdata_in[`CTRL_SLEEP_EN_BIT];
    end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      window_q <= `WIN_RESET;
      pair_cfg_q <= `PAIR_RESET;
    end
    else if (wr && (paddr_in == `OFS_TIMING) && stopped)
    begin
      window_q <= clamp11({21'h000000, pwdata_in[`TIMING_WIN_LSB +: 11]}, 11'h000,
                          `WIN_MAX);
      pair_cfg_q <= pwdata_in[`TIMING_PAIR_LSB +: 5];
    end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      damp_q <= `DAMP_RESET;
      chan_q <= `CHAN_AB;
      dec_q <= `DEC_RESET;
    end
    else if (wr && (paddr_in == `OFS_SYNC) && stopped)
    begin
      damp_q <= 5'(clamp11({27'h0000000, pwdata_in[`SYNC_DAMP_LSB +: 5]}, 11'h000,
                        {6'h00, `DAMP_MAX}));
      chan_q <= chan_fix(pwdata_in[`SYNC_CHAN_LSB +: 2]);
      dec_q <= 8'(clamp11({24'h000000, pwdata_in[`SYNC_DEC_LSB +: 8]}, {3'h0, `DEC_MIN},
                       {3'h0, `DEC_MAX}));
    end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      slot_q <= `SLOT_RESET;
    else if (wr && (paddr_in == `OFS_SLOT) && stopped)
      slot_q <= pwdata_in[10:0];

  // ************************************************************
  // sleep handling
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      asleep_q <= 1'b0;
    else if (wr && (paddr_in == `OFS_CTRL) && stopped && !pwdata_in[`CTRL_SLEEP_EN_BIT])
      asleep_q <= 1'b0;
    else if (wr && (paddr_in == `OFS_CTRL) && stopped && asleep_q)
      asleep_q <= 1'b1;
    else if (stop_cmd && !stopped)
      asleep_q <= sleep_en_q ? 1'b1 : asleep_q;
    else if ((state_q == POC_READY) && wake_seen)
      asleep_q <= 1'b0;

  // ************************************************************
  // protocol operation control
  // ************************************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      POC_CONFIG, POC_READY, POC_HALT:
      begin
        if (start_cmd)
          state_d = asleep_q ? POC_READY : POC_STARTUP;
        else if ((state_q == POC_READY) && asleep_q && wake_seen)
          state_d = POC_STARTUP;
        else if (state_q == POC_CONFIG)
          state_d = POC_CONFIG;
      end
      POC_STARTUP:
      begin
        if (stop_cmd)
          state_d = POC_READY;
        else if (integrated_in)
          state_d = POC_ACTIVE;
      end
      POC_ACTIVE:
      begin
        if (stop_cmd)
          state_d = POC_READY;
        else if (clock_error_in)
          state_d = POC_PASSIVE;
      end
      POC_PASSIVE:
      begin
        if (stop_cmd)
          state_d = POC_READY;
        else if (clock_error_in)
          state_d = halt_en_q ? POC_HALT : POC_PASSIVE;
        else if (cycle_end_in && cycle_odd_in && even_ok_q && corr_valid_in &&
                 (pair_cfg_q != 5'h00) && (pairs_q + 5'h01 >= pair_cfg_q))
          state_d = POC_ACTIVE;
      end
      default:
        state_d = POC_CONFIG;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      state_q <= POC_CONFIG;
    else
      state_q <= state_d;

  // consecutive valid even/odd pairs while passive
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      even_ok_q <= 1'b0;
      pairs_q <= 5'h00;
    end
    else if (state_q != POC_PASSIVE)
    begin
      even_ok_q <= 1'b0;
      pairs_q <= 5'h00;
    end
    else if (cycle_end_in && !cycle_odd_in)
      even_ok_q <= corr_valid_in;
    else if (cycle_end_in && cycle_odd_in)
    begin
      even_ok_q <= 1'b0;
      pairs_q <= (even_ok_q && corr_valid_in && pairs_q != 5'h1F) ?
                 pairs_q + 5'h01 : 5'h00;
    end

  // ************************************************************
  // startup frame transmission
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      tx_q <= 1'b0;
    else
      tx_q <= slot_start_in && (slot_q != 11'h000) && (slot_in == slot_q) &&
              !stopped;

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      prdata_q <= 32'h00000000;
    else if (setup && !pwrite_in)
    begin
      case (paddr_in)
        `OFS_CTRL:
          prdata_q <= {26'h0000000, sleep_en_q, halt_en_q, 4'h0};
        `OFS_TIMING:
          prdata_q <= {11'h000, pair_cfg_q, 5'h00, window_q};
        `OFS_SYNC:
          prdata_q <= {8'h00, dec_q, 6'h00, chan_q, 3'h0, damp_q};
        `OFS_SLOT:
          prdata_q <= {21'h000000, slot_q};
        `OFS_STATUS:
          prdata_q <= {11'h000, pairs_q, 6'h00, asleep_q, (slot_q != 11'h000),
                       2'h0, state_q};
        default:
          prdata_q <= 32'h00000000;
      endcase
    end

  // ************************************************************
  // sync arithmetic and outputs
  // ************************************************************
  assign sync.accept_window = window_q;
  assign sync.damping = damp_q;
  assign sync.decode_corr = dec_q;

  poc_sync_calc u_calc (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .sync(sync.calc),
    .start_dev_in(start_dev_in),
    .sync_frame_in(sync_frame_in),
    .secondary_trp_in(secondary_trp_in),
    .expected_in(expected_in),
    .raw_rate_in(raw_rate_in)
  );

  assign prdata_out = prdata_q;
  assign poc_state_out = state_q;
  assign asleep_out = asleep_q;
  assign coldstart_out = (slot_q != 11'h000);
  assign tx_startup_out = tx_q;
  assign channels_out = chan_q;
  assign startup_accept_out = sync.accept & (state_q == POC_STARTUP);
  assign deviation_out = sync.deviation;
  assign rate_corr_out = sync.rate_corr;

endmodule

`default_nettype wire

/* File: src/poc_params.svh */
// Purpose: register offsets, field positions, reset values and ranges of the node controller
// Assumes: included by its bare name
// Notes: definitions only
`ifndef POC_PARAMS_SVH
`define POC_PARAMS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_CTRL 8'h00
`define OFS_TIMING 8'h04
`define OFS_SYNC 8'h08
`define OFS_SLOT 8'h0C
`define OFS_STATUS 8'h10

// ************************************************************
// control register fields
// ************************************************************
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_HALT_EN_BIT 4
`define CTRL_SLEEP_EN_BIT 5

// ************************************************************
// field positions
// ************************************************************
`define TIMING_WIN_LSB 0
`define TIMING_PAIR_LSB 16
`define SYNC_DAMP_LSB 0
`define SYNC_CHAN_LSB 8
`define SYNC_DEC_LSB 16
`define STAT_STATE_LSB 0
`define STAT_COLD_BIT 8
`define STAT_SLEEP_BIT 9
`define STAT_PAIRS_LSB 16

// ************************************************************
// ranges and reset values
// ************************************************************
`define WIN_MAX 11'h753
`define WIN_RESET 11'h000
`define PAIR_RESET 5'h00
`define DAMP_MAX 5'h14
`define DAMP_RESET 5'h00
`define DEC_MIN 8'h0E
`define DEC_MAX 8'h8F
`define DEC_RESET 8'h0E
`define CHAN_A 2'h1
`define CHAN_B 2'h2
`define CHAN_AB 2'h3
`define SLOT_RESET 11'h000

`endif

/* File: src/poc_pkg.sv */
// Purpose: types shared by the node controller files
// Assumes: nothing
// Notes: states are one-hot
`default_nettype none

package poc_pkg;

  typedef enum logic [5:0] {
    POC_CONFIG = 6'h01,
    POC_READY = 6'h02,
    POC_STARTUP = 6'h04,
    POC_ACTIVE = 6'h08,
    POC_PASSIVE = 6'h10,
    POC_HALT = 6'h20
  } poc_state_t;

  typedef logic signed [15:0] mt_t;

endpackage

`default_nettype wire

/* File: src/poc_sync_if.sv */
// Purpose: carries configuration and results between controller and sync arithmetic
// Assumes: single clock
// Notes: controller owns configuration
`default_nettype none

interface poc_sync_if;
  import poc_pkg::*;
  logic [10:0] accept_window;
  logic [4:0] damping;
  logic [7:0] decode_corr;
  logic accept;
  mt_t deviation;
  mt_t rate_corr;

  modport ctrl (output accept_window, damping, decode_corr, input accept, deviation, rate_corr);
  modport calc (input accept_window, damping, decode_corr, output accept, deviation, rate_corr);
endinterface

`default_nettype wire

/* File: src/poc_sync_calc.sv */
// Purpose: startup acceptance, time reference offset and drift damping arithmetic
// Assumes: inputs synchronous to the clock
// Notes: results are registered
`default_nettype none
`include "poc_params.svh"

module poc_sync_calc
  import poc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  poc_sync_if.calc sync,
  // measurements
  input wire mt_t start_dev_in,
  input wire logic sync_frame_in,
  input wire mt_t secondary_trp_in,
  input wire mt_t expected_in,
  input wire mt_t raw_rate_in
);

  function automatic mt_t mag(input mt_t v);
    mag = v[15] ? -v : v;
  endfunction

  // startup frame deviation inside the accepted window
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      sync.accept <= 1'b0;
    else
      sync.accept <= (mag(start_dev_in) <= mt_t'({5'h00, sync.accept_window}));

  // primary point is secondary minus decoding correction, compared with expected arrival
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      sync.deviation <= 16'sh0000;
    else if (sync_frame_in)
      sync.deviation <= secondary_trp_in - mt_t'({8'h00, sync.decode_corr}) - expected_in;

  // drift damping shrinks the rate correction toward zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      sync.rate_corr <= 16'sh0000;
    else if (mag(raw_rate_in) <= mt_t'({11'h000, sync.damping}))
      sync.rate_corr <= 16'sh0000;
    else if (raw_rate_in[15])
      sync.rate_corr <= raw_rate_in + mt_t'({11'h000, sync.damping});
    else
      sync.rate_corr <= raw_rate_in - mt_t'({11'h000, sync.damping});

endmodule

`default_nettype wire

/* File: tb/poc_node_ctrl_chk.sv */
// Purpose: port-level checks of the node controller
// Assumes: bound into poc_node_ctrl, one clock domain
// Notes: window and damping seen only via effects
`default_nettype none

module poc_node_ctrl_chk
  import poc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  // cluster events
  input wire logic integrated_in,
  input wire logic clock_error_in,
  input wire logic cycle_end_in,
  input wire logic cycle_odd_in,
  input wire logic corr_valid_in,
  input wire logic wakeup_a_in,
  input wire logic wakeup_b_in,
  input wire logic slot_start_in,
  input wire mt_t start_dev_in,
  input wire mt_t raw_rate_in,
  // node outputs
  input wire logic [5:0] poc_state_out,
  input wire logic asleep_out,
  input wire logic coldstart_out,
  input wire logic tx_startup_out,
  input wire logic [1:0] channels_out,
  input wire logic startup_accept_out,
  input wire logic [15:0] rate_corr_out
);
  timeunit 1ns / 1ps;
  logic apb_wr;
  logic run_now;
  logic [15:0] rate_abs;
  logic [15:0] dev_abs_q;
  logic [15:0] raw_abs_q;

  assign apb_wr = psel_in & penable_in & pwrite_in;
  assign run_now = (poc_state_out & 6'h1C) != 6'h00;
  assign rate_abs = rate_corr_out[15] ? 16'(-rate_corr_out) : rate_corr_out;

  // magnitudes of the previous cycle's measurements
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dev_abs_q <= 16'h0000;
      raw_abs_q <= 16'h0000;
    end
    else
    begin
      dev_abs_q <= start_dev_in[15] ? 16'(-start_dev_in) : 16'(start_dev_in);
      raw_abs_q <= raw_rate_in[15] ? 16'(-raw_rate_in) : 16'(raw_rate_in);
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_accept;
    startup_accept_out |-> poc_state_out == POC_STARTUP && dev_abs_q <= 16'h0753;
  endproperty
  a_accept: assert property (p_accept)
    else $error("startup frame accepted outside window");
  property p_halt_src;
    $rose(poc_state_out == POC_HALT) |-> $past(poc_state_out == POC_PASSIVE && clock_error_in);
  endproperty
  a_halt_src: assert property (p_halt_src)
    else $error("halt entered without passive clock error");
  property p_err_passive;
    poc_state_out == POC_ACTIVE && clock_error_in && !apb_wr |=> poc_state_out == POC_PASSIVE;
  endproperty
  a_err_passive: assert property (p_err_passive)
    else $error("clock error in active did not give passive");
  property p_promote;
    poc_state_out == POC_ACTIVE && $past(poc_state_out) == POC_PASSIVE
      |-> $past(cycle_end_in && cycle_odd_in && corr_valid_in);
  endproperty
  a_promote: assert property (p_promote)
    else $error("promotion not at a valid odd cycle end");
  property p_integrate;
    poc_state_out == POC_ACTIVE && $past(poc_state_out) == POC_STARTUP |-> $past(integrated_in);
  endproperty
  a_integrate: assert property (p_integrate)
    else $error("active entered from startup without integration");
  property p_wake;
    poc_state_out == POC_STARTUP && $past(poc_state_out == POC_READY && asleep_out && !apb_wr)
      |-> $past(wakeup_a_in && channels_out[0] || wakeup_b_in && channels_out[1]);
  endproperty
  a_wake: assert property (p_wake)
    else $error("left ready asleep without wakeup on connected channel");
  property p_cold;
    tx_startup_out |-> coldstart_out && $past(slot_start_in) && $past(run_now);
  endproperty
  a_cold: assert property (p_cold)
    else $error("startup frame sent without coldstart or slot start");
  property p_damp;
    rate_abs <= raw_abs_q;
  endproperty
  a_damp: assert property (p_damp)
    else $error("damped rate larger than raw rate");
  property p_chan;
    channels_out != 2'h0;
  endproperty
  a_chan: assert property (p_chan)
    else $error("no channel connected");
  property p_freeze;
    run_now && $past(run_now) |-> $stable(channels_out);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("channel setting changed while running");
endmodule

bind poc_node_ctrl poc_node_ctrl_chk chk (.ref_clk_in, .rst_b_in, .psel_in, .penable_in,
  .pwrite_in, .integrated_in, .clock_error_in, .cycle_end_in, .cycle_odd_in, .corr_valid_in,
  .wakeup_a_in, .wakeup_b_in, .slot_start_in, .start_dev_in, .raw_rate_in, .poc_state_out,
  .asleep_out, .coldstart_out, .tx_startup_out, .channels_out, .startup_accept_out,
  .rate_corr_out);

`default_nettype wire

/* File: tb/poc_cluster_model.sv */
// Purpose: the other cluster nodes as seen by one node controller
// Assumes: tasks are called just after a rising edge
// Notes: events are one-cycle pulses, measurements are levels
`default_nettype none

module poc_cluster_model
(
  // clock
  input wire logic ref_clk_in,
  // cluster events
  output logic integrated_out,
  output logic clock_error_out,
  output logic slot_start_out,
  output logic [10:0] slot_out,
  output logic cycle_end_out,
  output logic cycle_odd_out,
  output logic corr_valid_out,
  output logic wakeup_a_out,
  output logic wakeup_b_out,
  // measurements
  output logic sync_frame_out,
  output logic [15:0] start_dev_out,
  output logic [15:0] raw_rate_out,
  output logic [15:0] secondary_out,
  output logic [15:0] expected_out
);
  timeunit 1ns / 1ps;
  initial
  begin
    {integrated_out, clock_error_out, slot_start_out, slot_out} = '0;
    {cycle_end_out, cycle_odd_out, corr_valid_out, wakeup_a_out, wakeup_b_out} = '0;
    {sync_frame_out, start_dev_out, raw_rate_out, secondary_out, expected_out} = '0;
  end

  // m = {integrated, clock error, slot start}
  task automatic ev(input logic [2:0] m, input logic [10:0] slot);
    {integrated_out, clock_error_out, slot_start_out} <= m;
    slot_out <= slot;
    @(posedge ref_clk_in);
    {integrated_out, clock_error_out, slot_start_out} <= 3'h0;
    @(posedge ref_clk_in);
  endtask

  // wakeup pattern only on the channel asked for
  task automatic wake(input logic [1:0] ch);
    {wakeup_b_out, wakeup_a_out} <= ch;
    @(posedge ref_clk_in);
    {wakeup_b_out, wakeup_a_out} <= 2'h0;
    @(posedge ref_clk_in);
  endtask

  task automatic pair(input logic [1:0] v);
    for (int i = 0; i < 2; i++)
    begin
      {cycle_end_out, cycle_odd_out, corr_valid_out} <= {1'b1, i[0], v[i]};
      @(posedge ref_clk_in);
    end
    cycle_end_out <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic meas(input logic [15:0] dev, input logic [15:0] raw);
    start_dev_out <= dev;
    raw_rate_out <= raw;
    repeat (3) @(posedge ref_clk_in);
  endtask

  task automatic sync(input logic [15:0] sec, input logic [15:0] exp);
    sync_frame_out <= 1'b1;
    secondary_out <= sec;
    expected_out <= exp;
    @(posedge ref_clk_in);
    sync_frame_out <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask
endmodule

`default_nettype wire

/* File: tb/flexray_node_poc_config_test.sv */
// Purpose: self-checking bench of the node controller
// Assumes: zero-wait apb slave, cluster model beside it
// Notes: every scenario judges its own results
`default_nettype none
`include "poc_params.svh"

module flexray_node_poc_config_test
  import poc_pkg::*;
;
  timeunit 1ns / 1ps;
  logic ref_clk_in = 1'b0;
  logic rst_b_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic integrated_in, clock_error_in, slot_start_in, cycle_end_in, cycle_odd_in;
  logic corr_valid_in, wakeup_a_in, wakeup_b_in, sync_frame_in;
  logic [10:0] slot_in;
  mt_t start_dev_in, raw_rate_in, secondary_trp_in, expected_in;
  logic [5:0] poc_state_out;
  logic asleep_out, coldstart_out, tx_startup_out, startup_accept_out;
  logic [1:0] channels_out;
  logic [15:0] deviation_out, rate_corr_out;
  int miscompares = 0;
  int n_checks = 0;
  int tx_cnt = 0;

  poc_node_ctrl dut (.ref_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .integrated_in, .clock_error_in,
    .cycle_end_in, .cycle_odd_in, .corr_valid_in, .wakeup_a_in, .wakeup_b_in, .slot_in,
    .slot_start_in, .start_dev_in, .sync_frame_in, .secondary_trp_in, .expected_in,
    .raw_rate_in, .poc_state_out, .asleep_out, .coldstart_out, .tx_startup_out,
    .channels_out, .startup_accept_out, .deviation_out, .rate_corr_out);
  poc_cluster_model cl (.ref_clk_in, .integrated_out(integrated_in),
    .clock_error_out(clock_error_in), .slot_start_out(slot_start_in), .slot_out(slot_in),
    .cycle_end_out(cycle_end_in), .cycle_odd_out(cycle_odd_in), .corr_valid_out(corr_valid_in),
    .wakeup_a_out(wakeup_a_in), .wakeup_b_out(wakeup_b_in), .sync_frame_out(sync_frame_in),
    .start_dev_out(start_dev_in), .raw_rate_out(raw_rate_in),
    .secondary_out(secondary_trp_in), .expected_out(expected_in));

  always #4 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
    if (tx_startup_out === 1'b1)
      tx_cnt <= tx_cnt + 1;

  task automatic tally_and_finish;
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      miscompares++;
      tally_and_finish();
    end
    r = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic st(input poc_state_t s);
    chk({26'h0, poc_state_out}, {26'h0, s});
  endtask

  task automatic s_defaults;
    logic [31:0] r;
    logic e;
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_TIMING, 32'h0);
    rd(`OFS_SYNC, 32'h000E0300);
    rd(`OFS_STATUS, 32'h1);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk({e, r}, 33'h100000000);
  endtask

  task automatic s_ranges;
    wr(`OFS_TIMING, 32'h001F07FF);
    rd(`OFS_TIMING, 32'h001F0753);
    wr(`OFS_SYNC, 32'h00C8001F);
    rd(`OFS_SYNC, 32'h008F0314);
    wr(`OFS_SYNC, 32'h00050000);
    rd(`OFS_SYNC, 32'h000E0300);
    for (int c = 1; c < 4; c++)
    begin
      wr(`OFS_SYNC, 32'h0014000A | (c << 8));
      rd(`OFS_SYNC, 32'h0014000A | (c << 8));
      chk(32'(channels_out), c);
    end
  endtask

  task automatic s_running;
    wr(`OFS_SLOT, 32'h0);
    chk(32'(coldstart_out), 32'h0);
    wr(`OFS_SLOT, 32'h5);
    wr(`OFS_TIMING, 32'h00000064);
    chk(32'(coldstart_out), 32'h1);
    wr(`OFS_CTRL, 32'h1);
    st(POC_STARTUP);
    cl.meas(16'h0064, 16'h0019);
    chk(32'(startup_accept_out), 32'h1);
    chk(32'(rate_corr_out), 32'h000F);
    cl.meas(16'hFF9C, 16'hFFE2);
    chk(32'(startup_accept_out), 32'h1);
    chk(32'(rate_corr_out), 32'hFFEC);
    cl.meas(16'h0065, 16'hFFFB);
    chk(32'(startup_accept_out), 32'h0);
    chk(32'(rate_corr_out), 32'h0);
    cl.sync(16'h01F4, 16'h0190);
    @(posedge ref_clk_in);
    chk(32'(deviation_out), 32'h0050);
    cl.ev(3'h1, 11'h005);
    cl.ev(3'h1, 11'h004);
    repeat (2) @(posedge ref_clk_in);
    chk(tx_cnt, 1);
    wr(`OFS_SYNC, 32'h00200105);
    rd(`OFS_SYNC, 32'h0014030A);
    cl.ev(3'h4, 11'h0);
    st(POC_ACTIVE);
    cl.ev(3'h2, 11'h0);
    st(POC_PASSIVE);
    cl.ev(3'h2, 11'h0);
    st(POC_PASSIVE);
    repeat (3) cl.pair(2'h3);
    st(POC_PASSIVE);
    wr(`OFS_CTRL, 32'h2);
    rd(`OFS_STATUS, 32'h102);
  endtask

  task automatic s_promote;
    wr(`OFS_TIMING, 32'h00020064);
    wr(`OFS_CTRL, 32'h11);
    cl.ev(3'h4, 11'h0);
    cl.ev(3'h2, 11'h0);
    cl.pair(2'h3);
    cl.pair(2'h1);
    cl.pair(2'h3);
    st(POC_PASSIVE);
    cl.pair(2'h3);
    st(POC_ACTIVE);
    cl.ev(3'h2, 11'h0);
    cl.ev(3'h2, 11'h0);
    st(POC_HALT);
  endtask

  task automatic s_sleep;
    wr(`OFS_CTRL, 32'h21);
    wr(`OFS_CTRL, 32'h2);
    rd(`OFS_STATUS, 32'h302);
    wr(`OFS_CTRL, 32'h20);
    rd(`OFS_STATUS, 32'h302);
    wr(`OFS_SYNC, 32'h0014010A);
    wr(`OFS_CTRL, 32'h21);
    st(POC_READY);
    cl.wake(2'h2);
    st(POC_READY);
    cl.wake(2'h1);
    rd(`OFS_STATUS, 32'h104);
    wr(`OFS_CTRL, 32'h2);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_STATUS, 32'h102);
  endtask

  initial
  begin
    rst_b_in = 1'b0;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    repeat (8) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    s_defaults();
    s_ranges();
    s_running();
    s_promote();
    s_sleep();
    tally_and_finish();
  end
endmodule

`default_nettype wire
